//--- rtl/ddps_dram_ctl.sv
// host controller driving the strobes and address of a two-die dynamic ram
module ddps_dram_ctl #(
  parameter int REF_CYC = ddps_pkg::REF_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [14:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_rdata,
  input wire logic supply_fault,
  output logic init_done,
  output logic dram_ras_n,
  output logic [1:0] dram_cas_n,
  output logic dram_we_n,
  output logic [6:0] dram_addr,
  output logic dram_din,
  input wire logic dram_dout
);

  ddps_ref_if rf ();

  ddps_pkg::ddps_state_e state_reg;
  ddps_pkg::ddps_cnt_t cnt_reg;
  ddps_pkg::ddps_cnt_t page_cnt_reg;
  logic ras_n_reg;
  logic [1:0] cas_n_reg;
  logic we_n_reg;
  logic [6:0] addr_reg;
  logic din_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic rsp_rdata_reg;
  logic init_done_reg;
  logic ack_reg;
  logic is_ref_reg;
  logic [6:0] open_row_reg;
  logic have_req_reg;
  logic q_write_reg;
  logic q_die_reg;
  logic [6:0] q_row_reg;
  logic [6:0] q_col_reg;
  logic q_wdata_reg;
  logic take;
  logic row_hit;

  assign take = req_valid && ready_reg;
  assign row_hit = (q_row_reg == open_row_reg);
  assign rf.ref_ack = ack_reg;

  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign init_done = init_done_reg;
  assign dram_ras_n = ras_n_reg;
  assign dram_cas_n = cas_n_reg;
  assign dram_we_n = we_n_reg;
  assign dram_addr = addr_reg;
  assign dram_din = din_reg;

  // kept apart so it can stay powered alone in standby
  ddps_refresh #(
    .REF_CYC(REF_CYC),
    .INIT_N(ddps_pkg::INIT_REFRESH_CYCLES)
  ) u_refresh (
    .clk(clk),
    .sys_rst(sys_rst),
    .rf(rf)
  );

  // column strobe pattern for one die; the other stays high
  function automatic logic [1:0] cas_for_die(input logic die);
    return die ? 2'b01 : 2'b10;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request holding register; ready is low whenever it is full
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      have_req_reg <= 1'b0;
      q_write_reg <= 1'b0;
      q_die_reg <= 1'b0;
      q_row_reg <= 7'h00;
      q_col_reg <= 7'h00;
      q_wdata_reg <= 1'b0;
    end else if (take) begin
      have_req_reg <= 1'b1;
      q_write_reg <= req_write;
      q_die_reg <= req_addr[ddps_pkg::DIE_BIT];
      q_row_reg <= req_addr[ddps_pkg::ROW_LSB +: ddps_pkg::ADDR_W];
      q_col_reg <= req_addr[ddps_pkg::COL_LSB +: ddps_pkg::ADDR_W];
      q_wdata_reg <= req_wdata;
    end else if (state_reg == ddps_pkg::ST_COL) begin
      have_req_reg <= 1'b0;
    end
  end

  // time the row strobe has been low, to bound a long page
  always_ff @(posedge clk) begin
    if (sys_rst || ras_n_reg) begin
      page_cnt_reg <= '0;
    end else if (page_cnt_reg != ddps_pkg::PAGE_LIMIT) begin
      page_cnt_reg <= page_cnt_reg + 9'h001;
    end
  end

  // status copy so the output comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= rf.init_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe sequencer; row strobe goes to both dies, column strobe is decoded
  // so a page spans both dies (trades standby power for page length)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ddps_pkg::ST_IDLE;
      cnt_reg <= '0;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 2'b11;
      we_n_reg <= 1'b1;
      addr_reg <= 7'h00;
      din_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 1'b0;
      ack_reg <= 1'b0;
      is_ref_reg <= 1'b0;
      open_row_reg <= 7'h00;
    end else begin
      ack_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      if (supply_fault) begin
        // an access in flight is dropped without a response
        ras_n_reg <= 1'b1;
        cas_n_reg <= 2'b11;
        we_n_reg <= 1'b1;
        ready_reg <= 1'b0;
        is_ref_reg <= 1'b0;
        cnt_reg <= ddps_pkg::PRE_CNT;
        state_reg <= ddps_pkg::ST_PRE;
      end else begin
        case (state_reg)
          ddps_pkg::ST_IDLE: begin
            if (rf.ref_req) begin
              addr_reg <= rf.ref_row;
              is_ref_reg <= 1'b1;
              ready_reg <= 1'b0;
              state_reg <= ddps_pkg::ST_ASET;
            end else if (have_req_reg) begin
              addr_reg <= q_row_reg;
              is_ref_reg <= 1'b0;
              ready_reg <= 1'b0;
              state_reg <= ddps_pkg::ST_ASET;
            end else begin
              ready_reg <= init_done_reg && !take;
            end
          end
          ddps_pkg::ST_ASET: begin
            ras_n_reg <= 1'b0;
            open_row_reg <= addr_reg;
            cnt_reg <= is_ref_reg ? ddps_pkg::RAS_MIN_CNT : ddps_pkg::RCD_CNT;
            state_reg <= ddps_pkg::ST_RAS;
          end
          ddps_pkg::ST_RAS: begin
            if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - 9'h001;
            end else if (is_ref_reg) begin
              // row-strobe-only refresh of both dies at once
              ras_n_reg <= 1'b1;
              ack_reg <= 1'b1;
              cnt_reg <= ddps_pkg::PRE_CNT;
              state_reg <= ddps_pkg::ST_PRE;
            end else begin
              addr_reg <= q_col_reg;
              we_n_reg <= !q_write_reg;
              din_reg <= q_wdata_reg;
              state_reg <= ddps_pkg::ST_COL;
            end
          end
          ddps_pkg::ST_COL: begin
            // one die only, so the shared output has one driver
            cas_n_reg <= cas_for_die(q_die_reg);
            cnt_reg <= ddps_pkg::CAS_CNT;
            state_reg <= ddps_pkg::ST_CAS;
          end
          ddps_pkg::ST_CAS: begin
            if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - 9'h001;
            end else begin
              // sampled before the column strobe rises and output floats
              if (!q_write_reg) begin
                rsp_rdata_reg <= dram_dout;
                rsp_valid_reg <= 1'b1;
              end
              cas_n_reg <= 2'b11;
              we_n_reg <= 1'b1;
              ready_reg <= 1'b1;
              state_reg <= ddps_pkg::ST_OPEN;
            end
          end
          ddps_pkg::ST_OPEN: begin
            if (rf.ref_req || page_cnt_reg == ddps_pkg::PAGE_LIMIT ||
                (have_req_reg && !row_hit)) begin
              ras_n_reg <= 1'b1;
              ready_reg <= 1'b0;
              cnt_reg <= ddps_pkg::PRE_CNT;
              state_reg <= ddps_pkg::ST_PRE;
            end else if (have_req_reg) begin
              // same row: new column only, row strobe stays low
              addr_reg <= q_col_reg;
              we_n_reg <= !q_write_reg;
              din_reg <= q_wdata_reg;
              ready_reg <= 1'b0;
              state_reg <= ddps_pkg::ST_COL;
            end else begin
              ready_reg <= !take;
            end
          end
          ddps_pkg::ST_PRE: begin
            if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - 9'h001;
            end else begin
              is_ref_reg <= 1'b0;
              state_reg <= ddps_pkg::ST_IDLE;
            end
          end
          default: begin
            ras_n_reg <= 1'b1;
            cas_n_reg <= 2'b11;
            state_reg <= ddps_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence seq_cas_fall;
    $fell(cas_n_reg[0]) || $fell(cas_n_reg[1]);
  endsequence

  sequence seq_page_col;
    state_reg == ddps_pkg::ST_OPEN && have_req_reg && row_hit &&
      !rf.ref_req && !supply_fault && page_cnt_reg != ddps_pkg::PAGE_LIMIT;
  endsequence

  chk_one_die_cas: assert property (cas_n_reg != 2'b00)
    else $error("both dies given column strobe");

  chk_cas_needs_ras: assert property (cas_n_reg != 2'b11 |-> !ras_n_reg)
    else $error("column strobe without row strobe");

  chk_fault_strobes: assert property (supply_fault |=> ras_n_reg && cas_n_reg == 2'b11)
    else $error("strobes not inactive on supply fault");

  chk_early_write: assert property (seq_cas_fall ##0 !we_n_reg |-> $past(!we_n_reg))
    else $error("write strobe not ahead of column strobe");

  chk_read_window: assert property (rsp_valid_reg |-> $past(cas_n_reg) != 2'b11
    && $past(cnt_reg) == '0)
    else $error("read data sampled outside column strobe");

  chk_init_gate: assert property (!init_done_reg |-> cas_n_reg == 2'b11 && !ready_reg)
    else $error("access before initialisation cycles");

  chk_page_hold: assert property (seq_page_col |=> !ras_n_reg [*3])
    else $error("row strobe released during page cycle");

  chk_ras_only_ref: assert property ($rose(ras_n_reg) && ack_reg |->
    $past(cas_n_reg == 2'b11, 1) && $past(cas_n_reg == 2'b11, 2))
    else $error("refresh cycle pulsed column strobe");

  chk_row_latch: assert property ($fell(ras_n_reg) |-> $stable(addr_reg))
    else $error("address moved at row strobe fall");

endmodule

//--- rtl/ddps_pkg.sv
// constants, timing and types shared by the dual-die dram controller
package ddps_pkg;

  // clock
  localparam int CLK_NS = 20;

  // address split: die select, row, column
  localparam int ADDR_W = 7;
  localparam int DIE_BIT = 14;
  localparam int ROW_LSB = 7;
  localparam int COL_LSB = 0;
  localparam int REQ_ADDR_W = 15;

  // refresh obligations
  localparam int REFRESH_WINDOW_MS = 2;
  localparam int REFRESH_ROWS = 128;
  localparam int INIT_REFRESH_CYCLES = 8;
  // longest spacing between row refreshes, rounded down
  localparam int REF_INTERVAL_CYC = (REFRESH_WINDOW_MS * 1000000 / CLK_NS) / REFRESH_ROWS;

  // strobe timing in ns (plain defaults)
  localparam int COLUMN_ACCESS_TIME_NS = 100;
  localparam int RAS_TO_CAS_NS = 40;
  localparam int RAS_PRECHARGE_NS = 120;
  localparam int RAS_MIN_NS = 200;
  localparam int RAS_MAX_NS = 10000;

  // least time to whole cycles, never under one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  typedef logic [8:0] ddps_cnt_t;

  localparam ddps_cnt_t CAS_CNT = ddps_cnt_t'(ns_to_cyc(COLUMN_ACCESS_TIME_NS));
  localparam ddps_cnt_t RCD_CNT = ddps_cnt_t'(ns_to_cyc(RAS_TO_CAS_NS));
  localparam ddps_cnt_t PRE_CNT = ddps_cnt_t'(ns_to_cyc(RAS_PRECHARGE_NS));
  localparam ddps_cnt_t RAS_MIN_CNT = ddps_cnt_t'(ns_to_cyc(RAS_MIN_NS));
  // longest time, rounded down, minus room to close the page
  localparam ddps_cnt_t PAGE_LIMIT = ddps_cnt_t'(RAS_MAX_NS / CLK_NS - 20);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ASET = 3'b001,
    ST_RAS = 3'b010,
    ST_COL = 3'b011,
    ST_CAS = 3'b100,
    ST_OPEN = 3'b101,
    ST_PRE = 3'b110
  } ddps_state_e;

endpackage

//--- rtl/ddps_ref_if.sv
// refresh handshake between the strobe sequencer and the refresh generator
interface ddps_ref_if;
  logic ref_req;
  logic [6:0] ref_row;
  logic ref_ack;
  logic init_done;

  modport ctl (
    input ref_req,
    input ref_row,
    input init_done,
    output ref_ack
  );

  modport gen (
    output ref_req,
    output ref_row,
    output init_done,
    input ref_ack
  );
endinterface

//--- rtl/ddps_refresh.sv
// refresh interval timer, refresh row counter and power-up initialisation count
module ddps_refresh #(
  parameter int REF_CYC = ddps_pkg::REF_INTERVAL_CYC,
  parameter int INIT_N = ddps_pkg::INIT_REFRESH_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  ddps_ref_if.gen rf
);

  logic [9:0] tick_cnt_reg;
  logic tick;
  logic pend_reg;
  logic [6:0] row_reg;
  logic [3:0] init_cnt_reg;
  logic init_done_reg;

  assign tick = (tick_cnt_reg == 10'(REF_CYC - 1));
  assign rf.ref_req = pend_reg;
  assign rf.ref_row = row_reg;
  assign rf.init_done = init_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // one row every interval keeps all rows inside the window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_reg <= 10'h000;
    end else if (tick) begin
      tick_cnt_reg <= 10'h000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 10'h001;
    end
  end

  // pending request; a tick in the ack cycle wins, so no row is skipped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_reg <= 1'b1; // start-up burst begins at once
    end else if (tick) begin
      pend_reg <= 1'b1;
    end else if (rf.ref_ack && init_cnt_reg >= 4'(INIT_N - 1)) begin
      pend_reg <= 1'b0;
    end
  end

  // row address generator, stepped by each completed refresh
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      row_reg <= 7'h00;
    end else if (rf.ref_ack) begin
      row_reg <= row_reg + 7'h01;
    end
  end

  // both dies see every refresh strobe, so one count serves both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_cnt_reg <= 4'h0;
      init_done_reg <= 1'b0;
    end else begin
      if (rf.ref_ack && init_cnt_reg != 4'(INIT_N)) begin
        init_cnt_reg <= init_cnt_reg + 4'h1;
      end
      init_done_reg <= (init_cnt_reg == 4'(INIT_N));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_tick_raises_req: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> rf.ref_req)
    else $error("refresh tick did not raise a request");

  chk_row_steps: assert property (@(posedge clk) disable iff (sys_rst)
    rf.ref_ack |=> rf.ref_row == 7'($past(rf.ref_row) + 7'h01))
    else $error("refresh row did not advance after ack");

  chk_init_count: assert property (@(posedge clk) disable iff (sys_rst)
    rf.init_done |-> init_cnt_reg == 4'(INIT_N))
    else $error("init done before enough refresh cycles");

endmodule

//--- test/ddps_dram_ctl_bench.sv
// self-checking bench for the dual-die dram controller
module ddps_dram_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF_CYC = 40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [14:0] req_addr = 15'h0000;
  logic req_wdata = 1'b0;
  logic supply_fault = 1'b0;
  logic req_ready, rsp_valid, rsp_rdata, init_done, dram_ras_n, dram_we_n, dram_din, dram_dout;
  logic [1:0] dram_cas_n;
  logic [6:0] dram_addr;
  logic [14:0] acc_addr;
  int viol, ras_falls, cas_falls;
  int n_errors = 0;
  int check_count = 0;
  int seed = 87596;
  logic ref_mem [0:32767];
  bit seen [0:32767];
  ////////////////////////////////////////////////////////////////////////////////
  // clock and instances; a short refresh interval keeps the run brief
  always #10 clk = ~clk;
  ddps_dram_ctl #(.REF_CYC(REF_CYC)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .supply_fault(supply_fault), .init_done(init_done),
    .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
    .dram_addr(dram_addr), .dram_din(dram_din), .dram_dout(dram_dout));
  ddps_dram_model #(.WIN_CYC(128 * REF_CYC + 600)) u_mem (.clk(clk), .ras_n(dram_ras_n),
    .cas_n(dram_cas_n), .we_n(dram_we_n), .addr(dram_addr), .din(dram_din),
    .dout(dram_dout), .viol(viol), .ras_falls(ras_falls), .cas_falls(cas_falls),
    .acc_addr(acc_addr));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string name, input logic [14:0] exp, input logic [14:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one request held until taken; reads wait for the response pulse
  task automatic xfer(input logic wr, input logic [14:0] a, input logic d);
    int n;
    int c0;
    n = 0;
    c0 = cas_falls;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    if (req_ready !== 1'b1) begin
      n_errors++;
      $display("unexpected request timeout at %h", a);
      test_done();
    end
    n = 0;
    if (wr) begin
      ref_mem[a] = d;
      seen[a] = 1'b1;
    end else begin
      do begin
        @(posedge clk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 300);
      if (seen[a]) begin
        check("read data", {14'h0000, ref_mem[a]}, {14'h0000, rsp_rdata});
      end
    end
    while (cas_falls == c0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    check("die row column", a, acc_addr);
    if (n >= 300) begin
      n_errors++;
      $display("unexpected access timeout at %h", a);
      test_done();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    int f0;
    int c0;
    logic [31:0] r;
    logic [14:0] a;
    logic [14:0] dirs [0:5];
    dirs = '{15'h0000, 15'h4000, 15'h007F, 15'h407F, 15'h3F80, 15'h7FFF};
    repeat (3) @(posedge clk);
    check("strobes in reset", 15'h000F, {11'h000, dram_ras_n, dram_cas_n, dram_we_n});
    sys_rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 2000);
    check("ready after start-up", 15'h0001, {14'h0000, req_ready});
    check("init done", 15'h0001, {14'h0000, init_done});
    check("wake-up refreshes", 15'h0001, (ras_falls >= 8) ? 15'h0001 : 15'h0000);
    check("column strobes in wake-up", 15'h0000, 15'(cas_falls));
    // same location in both dies with opposite data, then column ends
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, dirs[i], dirs[i][14] ^ dirs[i][0] ^ i[1]);
    end
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, dirs[i], 1'b0);
    end
    // random mix over two rows of each die, so pages hit and cross dies
    repeat (60) begin
      r = $random(seed);
      a = {r[2], 6'h00, r[3], r[10:4]};
      xfer(r[1] || !seen[a], a, r[11]);
    end
    // supply fault as a read is offered: strobes forced high, held request resumes after;
    // the last write is let finish first, since an access in flight is dropped
    repeat (8) @(posedge clk);
    fork
      xfer(1'b0, 15'h007F, 1'b0);
      begin
        supply_fault <= 1'b1;
        repeat (2) @(posedge clk);
        repeat (16) begin
          @(posedge clk);
          check("strobes in fault", 15'h0007, {12'h000, dram_ras_n, dram_cas_n});
        end
        supply_fault <= 1'b0;
      end
    join
    // idle: refresh goes on with row strobe only
    f0 = ras_falls;
    c0 = cas_falls;
    repeat (400) @(posedge clk);
    check("idle refreshes", 15'h0001, (ras_falls - f0 >= 9) ? 15'h0001 : 15'h0000);
    check("idle column strobes", 15'h0000, 15'(cas_falls - c0));
    check("model violations", 15'h0000, (viol == 0) ? 15'h0000 : 15'h0001);
    test_done();
  end
  // watchdog well past the expected run length
  initial begin
    #800000;
    n_errors++;
    $display("unexpected watchdog expiry");
    test_done();
  end
endmodule

//--- test/ddps_dram_model.sv
// behavioural two-die dynamic ram that answers the controller's strobes
module ddps_dram_model #(
  parameter int WIN_CYC = 5720
) (
  input wire logic clk,
  input wire logic ras_n,
  input wire logic [1:0] cas_n,
  input wire logic we_n,
  input wire logic [6:0] addr,
  input wire logic din,
  output logic dout,
  output int viol,
  output int ras_falls,
  output int cas_falls,
  output logic [14:0] acc_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mem [0:32767];
  logic [6:0] row_lat;
  logic early_wr;
  logic rd_bit;
  logic last_out;
  logic dout_on;
  int acc_cnt;
  int age [0:127];
  ////////////////////////////////////////////////////////////////////////////////
  // fixed pattern contents so that unwritten cells read as known values
  initial begin
    viol = 0;
    ras_falls = 0;
    cas_falls = 0;
    acc_addr = 15'h0000;
    early_wr = 1'b1;
    rd_bit = 1'b0;
    last_out = 1'b0;
    row_lat = 7'h00;
    acc_cnt = 0;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = i[0] ^ i[9];
    end
    for (int i = 0; i < 128; i++) begin
      age[i] = 0;
    end
  end
  // row latch on the row strobe fall; the row of both dies is refreshed
  always @(negedge ras_n) begin
    row_lat = addr;
    age[addr] = 0;
    ras_falls = ras_falls + 1;
  end
  // a die acts on any column strobe; one without the row strobe, on both dies, or before eight wake-up cycles is a violation
  task automatic col_fall(input logic die);
    cas_falls = cas_falls + 1;
    if (ras_n !== 1'b0 || cas_n === 2'b00 || ras_falls < 8) begin
      viol = viol + 1;
    end
    acc_addr = {die, row_lat, addr};
    early_wr = !we_n;
    if (!we_n) begin
      mem[{die, row_lat, addr}] = din;
    end
    rd_bit = mem[{die, row_lat, addr}];
  endtask
  always @(negedge cas_n[0]) col_fall(1'b0);
  always @(negedge cas_n[1]) col_fall(1'b1);
  // access time count and row ageing; a row left too long is a violation
  always @(posedge clk) begin
    acc_cnt <= (cas_n == 2'b11) ? 0 : acc_cnt + 1;
    if (dout_on) begin
      last_out <= rd_bit;
    end
    for (int i = 0; i < 128; i++) begin
      age[i] = age[i] + 1;
      if (age[i] == WIN_CYC) begin
        viol = viol + 1;
      end
    end
  end
  // output floats (shown as the inverse of the last bit) unless reading
  assign dout_on = (cas_n != 2'b11) && !early_wr &&
    (acc_cnt >= int'(ddps_pkg::CAS_CNT));
  assign dout = dout_on ? rd_bit : ~last_out;
endmodule
